// ==== design/ucp_far_end.sv ====
`timescale 1ns/1ps
module ucp_far_end
    import ucp_pkg::*;
#(
    parameter int BIT_2K_CYCLES  = BIT_2K_CYC,
    parameter int BIT_1K_CYCLES  = BIT_1K_CYC,
    parameter int BIT_125_CYCLES = BIT_125_CYC
)(
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    ucp_link_if.far               link,
    input  wire logic [1:0]       rate_sel,
    input  wire logic [7:0]       tx_byte,
    input  wire logic             tx_valid,
    output logic                  tx_ready,
    input  wire logic             proc_hold,
    output logic [15:0]           exec_word,
    output logic                  exec_stb,
    output logic [15:0]           data_word,
    output logic                  data_stb,
    output logic [15:0]           ver_word,
    output logic                  ver_stb
);

    logic [DIV_W-1:0] period;
    logic [DIV_W-1:0] div_q;
    logic [7:0]       sh_q;
    logic [2:0]       nbit_q;
    logic             busy_q;
    logic             line_q;
    logic             stb_q;
    logic             take;
    logic [1:0]       kind;
    logic             err;
    logic             syn_ok;
    logic [15:0]      exec_q;
    logic [15:0]      data_q;
    logic [15:0]      ver_q;
    logic             exec_stb_q;
    logic             data_stb_q;
    logic             ver_stb_q;

    always_comb begin
        case (ucp_rate_t'(rate_sel))
            RATE_1K:  period = DIV_W'(BIT_1K_CYCLES);
            RATE_125: period = DIV_W'(BIT_125_CYCLES);
            default:  period = DIV_W'(BIT_2K_CYCLES);
        endcase
    end

    assign tx_ready = !busy_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= '0;
            sh_q   <= 8'h0;
            nbit_q <= 3'h0;
            busy_q <= 1'b0;
            line_q <= 1'b0;
            stb_q  <= 1'b0;
        end else begin
            stb_q <= 1'b0;
            if (!busy_q) begin
                if (tx_valid) begin
                    sh_q   <= tx_byte;
                    busy_q <= 1'b1;
                    nbit_q <= 3'h0;
                    div_q  <= '0;
                end
            end else if (div_q == period - DIV_W'(1)) begin
                div_q  <= '0;
                line_q <= line_q ^ sh_q[7];
                sh_q   <= {sh_q[6:0], 1'b0};
                stb_q  <= 1'b1;
                nbit_q <= nbit_q + 3'h1;
                if (nbit_q == 3'h7) begin
                    busy_q <= 1'b0;
                end
            end else begin
                div_q <= div_q + DIV_W'(1);
            end
        end
    end

    assign link.ser_line  = line_q;
    assign link.ser_stb   = stb_q;
    assign link.cmd_ready = !proc_hold;

    assign take   = link.cmd_valid && !proc_hold;
    assign kind   = link.stat_word[1:0];
    assign err    = link.stat_word[STAT_ERR_BIT];
    assign syn_ok = !err && (kind != RC_RESERVED)
                    && !(kind == RC_PROC_CMD && link.cmd_word[15:8] == OPC_RESERVED);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            exec_q     <= 16'h0;
            data_q     <= 16'h0;
            ver_q      <= 16'h0;
            exec_stb_q <= 1'b0;
            data_stb_q <= 1'b0;
            ver_stb_q  <= 1'b0;
        end else begin
            exec_stb_q <= 1'b0;
            data_stb_q <= 1'b0;
            ver_stb_q  <= 1'b0;
            if (take) begin
                ver_q      <= {syn_ok, err, kind, link.cmd_word[11:0]};
                ver_stb_q  <= 1'b1;
                if (syn_ok && kind == RC_PROC_CMD) begin
                    exec_q     <= link.cmd_word;
                    exec_stb_q <= 1'b1;
                end
                if (syn_ok && kind == RC_PROC_DATA) begin
                    data_q     <= link.cmd_word;
                    data_stb_q <= 1'b1;
                end
            end
        end
    end

    assign exec_word = exec_q;
    assign exec_stb  = exec_stb_q;
    assign data_word = data_q;
    assign data_stb  = data_stb_q;
    assign ver_word  = ver_q;
    assign ver_stb   = ver_stb_q;

endmodule

// ==== design/ucp_link_if.sv ====
`timescale 1ns/1ps
interface ucp_link_if;
    logic        ser_line;
    logic        ser_stb;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [15:0] cmd_word;
    logic [15:0] stat_word;
    logic        irq;

    modport up (
        input  ser_line,
        input  ser_stb,
        input  cmd_ready,
        output cmd_valid,
        output cmd_word,
        output stat_word,
        output irq
    );

    modport far (
        output ser_line,
        output ser_stb,
        output cmd_ready,
        input  cmd_valid,
        input  cmd_word,
        input  stat_word,
        input  irq
    );
endinterface

// ==== design/ucp_pkg.sv ====
// Operation
// - Transponder delivers demodulated, bit-synchronized serial stream
// - Far end offers 2.0k, 125, 1.0k bps
// - Convert NRZ-M line to NRZ-L bits first
// - Find units, BCH-check blocks, unpack 32-bit commands
// - Unit: start pattern, 2..36 blocks, tail
// - Block: seven info bytes plus check byte
// - Bad block discards unit, counter unchanged
// - Split command: 14-bit count, 2-bit route, 16-bit
// - Compare count field with expected counter
// - Wrong count fails, never executed
// - Route code selects command, data or hardware
// - Hardware commands execute inside the interface
// - Executed hardware commands also forwarded to processor
// - Interrupt processor with word and status word
// - Status word holds kind and error flag
// - Two independent processors, one per controller
// - Processor checks syntax, reports verification words
package ucp_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int BIT_2K_NS     = 500000;
    localparam int BIT_1K_NS     = 1000000;
    localparam int BIT_125_NS    = 8000000;
    localparam int BIT_2K_CYC    = BIT_2K_NS / CLK_PERIOD_NS;
    localparam int BIT_1K_CYC    = BIT_1K_NS / CLK_PERIOD_NS;
    localparam int BIT_125_CYC   = BIT_125_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 18;

    localparam logic [15:0] START_SEQ = 16'hEB90;
    localparam logic [63:0] TAIL_SEQ  = 64'hC5C5C5C5C5C5C579;
    localparam logic [6:0]  BCH_POLY  = 7'h45;
    localparam int BLK_BITS   = 64;
    localparam int INFO_BITS  = 56;
    localparam int MIN_BLOCKS = 2;
    localparam int MAX_BLOCKS = 36;
    localparam int UNIT_BYTES = 256;

    localparam int CNT_MSB = 31;
    localparam int CNT_LSB = 18;
    localparam int RC_MSB  = 17;
    localparam int RC_LSB  = 16;
    localparam int CNT_W   = 14;
    localparam logic [CNT_W-1:0] EXP_CNT_RST = 14'h0000;

    localparam int STAT_ERR_BIT = 2;
    localparam int VER_ACC_BIT  = 15;
    localparam int VER_ERR_BIT  = 14;
    localparam logic [7:0] OPC_RESERVED = 8'hFF;
    localparam int FIFO_DEPTH   = 2;

    typedef enum logic [1:0] {
        RC_PROC_CMD  = 2'h0,
        RC_PROC_DATA = 2'h1,
        RC_HW_CMD    = 2'h2,
        RC_RESERVED  = 2'h3
    } ucp_route_t;

    typedef enum logic [1:0] {
        RATE_2K  = 2'h0,
        RATE_1K  = 2'h1,
        RATE_125 = 2'h2
    } ucp_rate_t;

endpackage

// ==== design/ucp_uplink_proc.sv ====
`timescale 1ns/1ps
module ucp_uplink_proc
    import ucp_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    ucp_link_if.up                link,
    output logic [15:0]           hw_cmd,
    output logic                  hw_cmd_stb,
    output logic                  unit_acc_stb,
    output logic                  unit_rej_stb,
    output logic [CNT_W-1:0]      exp_count
);

    typedef enum logic [1:0] {ST_HUNT, ST_BLOCK, ST_DRAIN} ucp_state_t;

    ucp_state_t       state_q;
    logic             prev_line_q;
    logic             nrzl_bit;
    logic [63:0]      shreg_q;
    logic [63:0]      shreg_d;
    logic [5:0]       bitcnt_q;
    logic [6:0]       crc_q;
    logic [5:0]       blk_cnt_q;
    logic [7:0]       byte_ptr_q;
    logic [7:0]       blk_base_q;
    logic [5:0]       n_words_q;
    logic [5:0]       rd_idx_q;
    logic [7:0]       ubytes [0:UNIT_BYTES-1];
    logic [CNT_W-1:0] exp_q;
    logic [15:0]      hw_cmd_q;
    logic             hw_stb_q;
    logic             acc_q;
    logic             rej_q;
    logic             sync_hit;
    logic             blk_end;
    logic             bch_ok;
    logic             is_tail;
    logic             byte_done;
    logic [31:0]      cur_word;
    ucp_route_t       route;
    logic             cnt_ok;
    logic             good;
    logic             drain_fire;
    logic             drain_last;
    logic [15:0]      stat_d;
    logic [31:0]      fifo_mem [0:FIFO_DEPTH-1];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       fifo_cnt_q;
    logic             fifo_full;
    logic             pop;

    assign nrzl_bit = link.ser_line ^ prev_line_q;
    assign shreg_d  = {shreg_q[62:0], nrzl_bit};

    assign sync_hit  = (state_q == ST_HUNT) && link.ser_stb && (shreg_d[15:0] == START_SEQ);
    assign blk_end   = (state_q == ST_BLOCK) && link.ser_stb && (bitcnt_q == 6'(BLK_BITS - 1));
    assign is_tail   = (shreg_d == TAIL_SEQ);
    // Check byte: inverted parity, zero filler
    assign bch_ok    = (shreg_d[7:1] == ~crc_q) && !shreg_d[0];
    // Nothing is stored past the last legal block, so the store never wraps onto word 0
    assign byte_done = (state_q == ST_BLOCK) && link.ser_stb && (bitcnt_q[2:0] == 3'h7)
                       && (bitcnt_q < 6'(INFO_BITS)) && (blk_cnt_q != 6'(MAX_BLOCKS));

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_line_q <= 1'b0;
            shreg_q     <= 64'h0;
        end else if (link.ser_stb) begin
            prev_line_q <= link.ser_line;
            shreg_q     <= shreg_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_HUNT;
        end else begin
            case (state_q)
                ST_HUNT: begin
                    if (sync_hit) begin
                        state_q <= ST_BLOCK;
                    end
                end
                ST_BLOCK: begin
                    if (blk_end) begin
                        if (is_tail) begin
                            state_q <= (blk_cnt_q >= 6'(MIN_BLOCKS)) ? ST_DRAIN : ST_HUNT;
                        end else if (!bch_ok || blk_cnt_q == 6'(MAX_BLOCKS)) begin
                            state_q <= ST_HUNT;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (drain_fire && drain_last) begin
                        state_q <= ST_HUNT;
                    end
                end
                default: state_q <= ST_HUNT;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bitcnt_q <= 6'h0;
            crc_q    <= 7'h0;
        end else if (sync_hit || blk_end) begin
            bitcnt_q <= 6'h0;
            crc_q    <= 7'h0;
        end else if ((state_q == ST_BLOCK) && link.ser_stb) begin
            bitcnt_q <= bitcnt_q + 6'h1;
            if (bitcnt_q < 6'(INFO_BITS)) begin
                crc_q <= {crc_q[5:0], 1'b0} ^ ((nrzl_bit ^ crc_q[6]) ? BCH_POLY : 7'h0);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (byte_done) begin
            ubytes[byte_ptr_q] <= shreg_d[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_ptr_q <= 8'h0;
            blk_base_q <= 8'h0;
            blk_cnt_q  <= 6'h0;
            n_words_q  <= 6'h0;
        end else if (sync_hit) begin
            byte_ptr_q <= 8'h0;
            blk_base_q <= 8'h0;
            blk_cnt_q  <= 6'h0;
        end else begin
            if (byte_done) begin
                byte_ptr_q <= byte_ptr_q + 8'h1;
            end
            if (blk_end && !is_tail && bch_ok) begin
                blk_base_q <= byte_ptr_q;
                blk_cnt_q  <= blk_cnt_q + 6'h1;
            end
            // Release only bytes of checked blocks
            if (blk_end && is_tail) begin
                n_words_q <= blk_base_q[7:2];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            acc_q <= blk_end && is_tail && (blk_cnt_q >= 6'(MIN_BLOCKS));
            rej_q <= blk_end && (is_tail ? (blk_cnt_q < 6'(MIN_BLOCKS))
                                         : (!bch_ok || blk_cnt_q == 6'(MAX_BLOCKS)));
        end
    end

    assign cur_word = {ubytes[{rd_idx_q, 2'h0}], ubytes[{rd_idx_q, 2'h1}],
                       ubytes[{rd_idx_q, 2'h2}], ubytes[{rd_idx_q, 2'h3}]};
    assign route    = ucp_route_t'(cur_word[RC_MSB:RC_LSB]);
    assign cnt_ok   = (cur_word[CNT_MSB:CNT_LSB] == exp_q);
    assign good     = cnt_ok && (route != RC_RESERVED);
    assign drain_fire = (state_q == ST_DRAIN) && !fifo_full;
    assign drain_last = (rd_idx_q == n_words_q - 6'h1);

    // Status word: kind and error flag
    always_comb begin
        stat_d               = 16'h0;
        stat_d[1:0]          = route;
        stat_d[STAT_ERR_BIT] = !good;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_idx_q <= 6'h0;
        end else if (blk_end) begin
            rd_idx_q <= 6'h0;
        end else if (drain_fire) begin
            rd_idx_q <= rd_idx_q + 6'h1;
        end
    end

    // Counter private to this processor instance
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            exp_q <= EXP_CNT_RST;
        end else if (drain_fire && good) begin
            exp_q <= exp_q + 14'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hw_cmd_q <= 16'h0;
            hw_stb_q <= 1'b0;
        end else begin
            hw_stb_q <= 1'b0;
            if (drain_fire && good && route == RC_HW_CMD) begin
                hw_cmd_q <= cur_word[15:0];
                hw_stb_q <= 1'b1;
            end
        end
    end

    // Every drained word, hardware ones too, goes to the processor buffer
    assign fifo_full = (fifo_cnt_q == 2'(FIFO_DEPTH));
    assign pop       = (fifo_cnt_q != 2'h0) && link.cmd_ready;

    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_fifo
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                fifo_mem[i] <= 32'h0;
            end else if (drain_fire && wr_ptr_q == 1'(i)) begin
                fifo_mem[i] <= {stat_d, cur_word[15:0]};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q   <= 1'b0;
            rd_ptr_q   <= 1'b0;
            fifo_cnt_q <= 2'h0;
        end else begin
            if (drain_fire) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            fifo_cnt_q <= fifo_cnt_q + 2'(drain_fire) - 2'(pop);
        end
    end

    // Interrupt while a word is waiting
    assign link.cmd_valid = (fifo_cnt_q != 2'h0);
    assign link.irq       = (fifo_cnt_q != 2'h0);
    assign link.cmd_word  = fifo_mem[rd_ptr_q][15:0];
    assign link.stat_word = fifo_mem[rd_ptr_q][31:16];

    assign hw_cmd       = hw_cmd_q;
    assign hw_cmd_stb   = hw_stb_q;
    assign unit_acc_stb = acc_q;
    assign unit_rej_stb = rej_q;
    assign exp_count    = exp_q;

endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb
    import ucp_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [1:0]        rate_sel = 2'h0;
    logic [7:0]        tx_byte = 8'h00;
    logic              tx_valid = 1'b0;
    logic              tx_ready;
    logic              proc_hold = 1'b0;
    logic [15:0]       hw_cmd, exec_word, data_word, ver_word;
    logic              hw_cmd_stb, unit_acc_stb, unit_rej_stb, exec_stb, data_stb, ver_stb;
    logic [CNT_W-1:0]  exp_count;
    int                n_fail = 0;
    int                check_count = 0;
    int                n_acc = 0;
    int                n_rej = 0;
    logic              prev = 1'b0;
    logic [63:0]       bits = 64'h0;
    logic [31:0]       dq[$];
    logic [15:0]       hq[$], xq[$], aq[$], vq[$];

    ucp_link_if link ();
    ucp_uplink_proc u_ucp_uplink_proc (.ref_clk(ref_clk), .arst_n(arst_n), .link(link), .hw_cmd(hw_cmd),
        .hw_cmd_stb(hw_cmd_stb), .unit_acc_stb(unit_acc_stb), .unit_rej_stb(unit_rej_stb), .exp_count(exp_count));
    ucp_far_end #(.BIT_2K_CYCLES(4), .BIT_1K_CYCLES(6), .BIT_125_CYCLES(8)) u_ucp_far_end (
        .ref_clk(ref_clk), .arst_n(arst_n), .link(link), .rate_sel(rate_sel), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .proc_hold(proc_hold), .exec_word(exec_word),
        .exec_stb(exec_stb), .data_word(data_word), .data_stb(data_stb), .ver_word(ver_word), .ver_stb(ver_stb));
    ucp_link_asserts u_ucp_link_asserts (.ref_clk(ref_clk), .arst_n(arst_n), .ser_line(link.ser_line),
        .ser_stb(link.ser_stb), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .cmd_word(link.cmd_word), .stat_word(link.stat_word), .irq(link.irq));

    always #20 ref_clk = ~ref_clk;

    // Records every delivered word and decodes the line back to plain bits
    always @(posedge ref_clk) begin
        if (link.cmd_valid && link.cmd_ready) dq.push_back({link.stat_word, link.cmd_word});
        if (hw_cmd_stb) hq.push_back(hw_cmd);
        if (exec_stb) xq.push_back(exec_word);
        if (data_stb) aq.push_back(data_word);
        if (ver_stb) vq.push_back(ver_word);
        if (unit_acc_stb) n_acc++;
        if (unit_rej_stb) n_rej++;
        if (link.ser_stb) begin
            bits = {bits[62:0], link.ser_line ^ prev};
            prev = link.ser_line;
        end
    end

    function automatic logic [7:0] bch(input logic [55:0] d);
        logic [6:0] s;
        logic       fb;
        s = 7'h00;
        for (int i = 55; i >= 0; i--) begin
            fb = d[i] ^ s[6];
            s = {s[5:0], 1'b0};
            if (fb) s = s ^ BCH_POLY;
        end
        return {~s, 1'b0};
    endfunction

    function automatic logic [31:0] mk(input logic [13:0] n, input logic [1:0] r, input logic [15:0] w);
        return {n, r, w};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic send_byte(input logic [7:0] b);
        int t;
        t = 0;
        tx_byte <= b;
        tx_valid <= 1'b1;
        do begin
            @(posedge ref_clk);
            t++;
        end while (tx_ready !== 1'b1 && t < 2000);
        `CHK("byte taken", 1'b1, tx_ready)
        tx_valid <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic send_unit(input logic [31:0] c [3], input int nc, input int nb, input bit bad);
        int          k;
        int          t;
        logic [7:0]  ib;
        logic [7:0]  par;
        logic [55:0] info;
        k = n_acc + n_rej;
        t = 0;
        info = 56'h0;
        dq.delete(); hq.delete(); xq.delete(); aq.delete(); vq.delete();
        send_byte(START_SEQ[15:8]);
        send_byte(START_SEQ[7:0]);
        for (int b = 0; b < nb; b++) begin
            for (int j = 0; j < 7; j++) begin
                ib = (b * 7 + j < 4 * nc) ? c[(b * 7 + j) / 4][31 - 8 * ((b * 7 + j) % 4) -: 8] : 8'h55;
                info = {info[47:0], ib};
                send_byte(ib);
            end
            par = bch(info);
            if (bad && b == nb - 1) par = par ^ 8'h02;
            send_byte(par);
        end
        for (int i = 7; i >= 0; i--) send_byte(TAIL_SEQ[8 * i +: 8]);
        while (n_acc + n_rej == k && t < 3000) begin
            @(posedge ref_clk);
            t++;
        end
        `CHK("unit ended", 1'b1, n_acc + n_rej != k)
        repeat (30) @(posedge ref_clk);
    endtask

    task automatic t_good();
        int a;
        a = n_acc;
        rate_sel <= 2'h0;
        send_unit('{mk(14'h0000, RC_PROC_CMD, 16'h1234), mk(14'h0001, RC_PROC_DATA, 16'h00AB),
                    mk(14'h0002, RC_HW_CMD, 16'h0C0D)}, 3, 2, 1'b0);
        `CHK("unit accepted", a + 1, n_acc)
        `CHK("tail on wire", TAIL_SEQ, bits)
        `CHK("expected count", 14'h0003, exp_count)
        `CHK("words delivered", 3, dq.size())
        `CHK("word0", 32'h0000_1234, dq[0])
        `CHK("word1", 32'h0001_00AB, dq[1])
        `CHK("word2", 32'h0002_0C0D, dq[2])
        `CHK("hw executed", 16'h0C0D, hq[0])
        `CHK("cmd executed", 16'h1234, xq[0])
        `CHK("data taken", 16'h00AB, aq[0])
        `CHK("verif words", 3, vq.size())
        $display("test good unit done");
    endtask

    task automatic t_reject(input int nb, input logic [CNT_W-1:0] ec);
        int r;
        r = n_rej;
        send_unit('{mk(14'h0003, RC_PROC_CMD, 16'h0101), mk(14'h0004, RC_HW_CMD, 16'h0202),
                    mk(14'h0005, RC_PROC_CMD, 16'h0303)}, 3, nb, nb == 2);
        `CHK("unit rejected", r + 1, n_rej)
        `CHK("count kept", ec, exp_count)
        `CHK("nothing released", 0, dq.size())
        `CHK("no hw run", 0, hq.size())
        $display("test reject unit done");
    endtask

    task automatic t_wrong();
        rate_sel <= 2'h1;
        send_unit('{mk(14'h0005, RC_PROC_CMD, 16'h1111), mk(14'h0003, RC_RESERVED, 16'h2222),
                    mk(14'h0003, RC_PROC_CMD, 16'h3333)}, 3, 2, 1'b0);
        `CHK("count after bad", 14'h0004, exp_count)
        `CHK("stale flagged", 32'h0004_1111, dq[0])
        `CHK("reserved flagged", 32'h0007_2222, dq[1])
        `CHK("good passed", 32'h0000_3333, dq[2])
        `CHK("one executed", 1, xq.size())
        `CHK("exec word", 16'h3333, xq[0])
        `CHK("stale verif", 16'h4111, vq[0])
        `CHK("good verif", 16'h8333, vq[2])
        $display("test wrong count done");
    endtask

    task automatic t_stall();
        rate_sel <= 2'h2;
        proc_hold <= 1'b1;
        send_unit('{mk(14'h0004, RC_PROC_DATA, 16'h4444), mk(14'h0005, RC_HW_CMD, 16'h5555),
                    mk(14'h0006, RC_PROC_CMD, 16'hFF66)}, 3, 2, 1'b0);
        `CHK("still offered", 1'b1, link.cmd_valid)
        `CHK("none taken", 0, dq.size())
        `CHK("hw while held", 16'h5555, hq[0])
        proc_hold <= 1'b0;
        repeat (10) @(posedge ref_clk);
        `CHK("all delivered", 3, dq.size())
        `CHK("first kept", 16'h4444, dq[0][15:0])
        `CHK("last kept", 16'hFF66, dq[2][15:0])
        `CHK("count at end", 14'h0007, exp_count)
        `CHK("bad opcode refused", 0, xq.size())
        `CHK("refusal recorded", 16'h0F66, vq[2])
        $display("test stall done");
    endtask

    task automatic t_long();
        int a;
        a = n_acc;
        rate_sel <= 2'h0;
        send_unit('{mk(14'h0007, RC_PROC_DATA, 16'h7777), mk(14'h0008, RC_PROC_CMD, 16'h8888),
                    mk(14'h0009, RC_HW_CMD, 16'h9999)}, 3, MAX_BLOCKS, 1'b0);
        repeat (60) @(posedge ref_clk);
        `CHK("long accepted", a + 1, n_acc)
        `CHK("long words", 63, dq.size())
        `CHK("long first", 32'h0001_7777, dq[0])
        `CHK("long count", 14'h000A, exp_count)
        `CHK("long hw", 16'h9999, hq[0])
        $display("test longest unit done");
    endtask

    initial begin
        #1600000;
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_good();
        t_reject(2, 14'h0003);
        t_reject(1, 14'h0003);
        t_wrong();
        t_stall();
        t_long();
        t_reject(37, 14'h000A);
        report_and_stop();
    end
endmodule

// ==== testbench/ucp_link_asserts.sv ====
`timescale 1ns/1ps
module ucp_link_asserts
    import ucp_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        ser_line,
    input wire logic        ser_stb,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [15:0] cmd_word,
    input wire logic [15:0] stat_word,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_irq_tracks_valid: assert property (irq == cmd_valid)
        else $error("irq differs from cmd_valid");
    a_stat_upper_zero: assert property (cmd_valid |-> stat_word[15:3] == 13'h0000)
        else $error("status word spare bits set");
    a_reserved_has_err: assert property (cmd_valid && stat_word[1:0] == RC_RESERVED |-> stat_word[STAT_ERR_BIT])
        else $error("reserved route without error flag");
    a_valid_held: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
        else $error("buffered word dropped during stall");
    a_word_held: assert property (cmd_valid && !cmd_ready |=> $stable(cmd_word))
        else $error("command word changed during stall");
    a_stat_held: assert property (cmd_valid && !cmd_ready |=> $stable(stat_word))
        else $error("status word changed during stall");
    a_stb_single: assert property (ser_stb |=> !ser_stb)
        else $error("bit strobe longer than one cycle");
    a_quiet_after_reset: assert property ($rose(arst_n) |-> !cmd_valid [*8])
        else $error("word offered without a unit");
    a_stb_after_reset: assert property ($rose(arst_n) |-> !ser_stb [*3])
        else $error("bit strobe too early after reset");

    c_stall: cover property (cmd_valid && !cmd_ready);
    c_hw_word: cover property (cmd_valid && cmd_ready && stat_word[1:0] == RC_HW_CMD);
    c_err_word: cover property (cmd_valid && stat_word[STAT_ERR_BIT]);
    c_one_bit: cover property (ser_stb && ser_line);
endmodule
